// ===== hdl/tmr8_top.sv
// Eight-bit timer with clear-on-match and two PWM modes behind an APB slave
//
// Operation
// - Clear-on-match mode clears the count after it equals the compare value.
// - Clear-on-match compare value is unbuffered; a low write waits for wrap.
// - Clear-on-match with action 1 inverts the output on every match.
// - The pin shows the output state only while its direction bit says output.
// - Clear-on-match sets overflow on the tick the count goes from max to zero.
// - Fast PWM counts up bottom to max, then restarts at bottom.
// - Fast PWM increments to max and clears to bottom on the next tick.
// - Fast PWM sets overflow every time the count reaches max.
// - Fast PWM action 2 clears on match, sets at max; action 3 reverses.
// - Fast PWM compare at bottom gives a spike; at max a constant level.
// - Fast PWM action 1 toggles on match, compare value still buffered.
// - Phase correct PWM counts up to max, then down to bottom, repeatedly.
// - Phase correct PWM turns at max and holds max for one tick.
// - Phase correct action 2 clears on up match, sets on down; 3 inverts.
// - Phase correct PWM sets overflow each time the count reaches bottom.
// - Phase correct compare at bottom gives constant low, at max constant high.
// - Phase correct PWM always has eight bits of resolution.
// - All logic runs on the I/O clock; the tick is only an enable.
// - The tick is the I/O clock divided by 1, 8, 64, 256 or 1024.
// - Clear-on-match raises the compare match flag once per period.
// - Clear-on-match toggle period is 2 times prescale times one plus compare.
// - PWM period is prescale times 256 in fast, times 510 in phase correct.
// - PWM modes load the compare value at the extreme; others at once.
// - Maximum count is 0xff and bottom is 0x00.
// - Compare match flag sets on the tick after the count equals compare.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "tmr8_params.svh"
module tmr8_top
	import tmr8_pkg::*;
#(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic compare_pin_out,
	output logic compare_pin_oe_n
);

	initial begin
		if (ADDR_WIDTH < 5 || ADDR_WIDTH > 32) begin
			$error("Address must reach all five registers");
		end
	end

	tmr8_tick_if tick_bus ();

	tmr8_prescaler #(
		.DIV_WIDTH(`TMR8_PRESCALE_WIDTH)
	) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.tick_bus(tick_bus.prescaler)
	);

	tmr8_state_t st;
	tmr8_state_t next_st;

	function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] ofs);
		addr_is = 32'(addr) == {24'h00_0000, ofs};
	endfunction

	function automatic logic is_pwm(input tmr8_mode_t mode);
		is_pwm = mode == tmr8_fast_pwm || mode == tmr8_phase_pwm;
	endfunction

	// Toggle, clear or set on a match; off leaves the state alone
	function automatic logic match_action(input logic [1:0] action, input logic cur);
		case (action)
			`TMR8_ACT_TOGGLE: match_action = ~cur;
			`TMR8_ACT_CLEAR: match_action = 1'b0;
			`TMR8_ACT_SET: match_action = 1'b1;
			default: match_action = cur;
		endcase
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_WIDTH-1:0] addr);
		addr_mapped = addr_is(addr, `TMR8_OFS_CTRL) || addr_is(addr, `TMR8_OFS_COUNT) ||
			addr_is(addr, `TMR8_OFS_COMPARE) || addr_is(addr, `TMR8_OFS_STATUS) ||
			addr_is(addr, `TMR8_OFS_DIR);
	endfunction

	logic setup_done;
	logic wr_done;
	logic hit;
	logic at_max;
	logic at_bot;
	logic top_special;
	logic [31:0] read_word;

	assign setup_done = psel && penable && !st.pready;
	// Writes land on the completing edge only
	assign wr_done = psel && penable && st.pready && pwrite;
	assign hit = st.count == st.compare_act && !st.block;
	assign at_max = st.count == `TMR8_MAX;
	assign at_bot = st.count == `TMR8_BOTTOM;
	// Compare at max with clear or set: match ignored, level set at the top
	assign top_special = st.compare_act == `TMR8_MAX && st.action[1];

	always_comb begin
		read_word = `TMR8_RESET_WORD;
		if (addr_is(paddr, `TMR8_OFS_CTRL)) begin
			read_word[`TMR8_CTRL_MODE_MSB:`TMR8_CTRL_MODE_LSB] = st.mode;
			read_word[`TMR8_CTRL_ACTION_MSB:`TMR8_CTRL_ACTION_LSB] = st.action;
			read_word[`TMR8_CTRL_CS_MSB:`TMR8_CTRL_CS_LSB] = st.clock_select;
		end else if (addr_is(paddr, `TMR8_OFS_COUNT)) begin
			read_word[7:0] = st.count;
		end else if (addr_is(paddr, `TMR8_OFS_COMPARE)) begin
			read_word[7:0] = st.compare_buf;
		end else if (addr_is(paddr, `TMR8_OFS_STATUS)) begin
			read_word[`TMR8_STATUS_OVF_BIT] = st.overflow_flag;
			read_word[`TMR8_STATUS_CMP_BIT] = st.compare_match_flag;
		end else if (addr_is(paddr, `TMR8_OFS_DIR)) begin
			read_word[`TMR8_DIR_BIT] = st.direction;
		end
	end

	always_comb begin
		next_st = st;

		// One wait state: answer is registered on the second access cycle
		next_st.pready = setup_done;
		if (setup_done) begin
			next_st.prdata = read_word;
			next_st.pslverr = !addr_mapped(paddr);
		end else begin
			next_st.pslverr = 1'b0;
		end

		// Clear first so a tick in the same cycle still sets the flag
		if (wr_done && addr_is(paddr, `TMR8_OFS_STATUS)) begin
			if (pwdata[`TMR8_STATUS_OVF_BIT]) begin
				next_st.overflow_flag = 1'b0;
			end
			if (pwdata[`TMR8_STATUS_CMP_BIT]) begin
				next_st.compare_match_flag = 1'b0;
			end
		end

		// Counting and flag setting only on the tick enable
		if (tick_bus.tick) begin
			next_st.block = 1'b0;
			next_st.match_pending = hit;
			if (st.match_pending) begin
				next_st.compare_match_flag = 1'b1;
			end
			case (st.mode)
				tmr8_clear_on_match: begin
					if (hit) begin
						next_st.count = `TMR8_BOTTOM;
						next_st.compare_output = match_action(st.action, st.compare_output);
					end else begin
						// Missed top runs on through max and wraps
						next_st.count = st.count + `TMR8_ONE;
					end
					if (at_max) begin
						next_st.overflow_flag = 1'b1;
					end
				end
				tmr8_fast_pwm: begin
					next_st.count = st.count + `TMR8_ONE;
					if (at_max) begin
						next_st.overflow_flag = 1'b1;
						next_st.compare_act = st.compare_buf;
					end
					if (at_max && st.action[1]) begin
						next_st.compare_output = !st.action[0];
					end else if (hit && !top_special) begin
						next_st.compare_output = match_action(st.action, st.compare_output);
					end
				end
				tmr8_phase_pwm: begin
					if (!st.count_down) begin
						if (at_max) begin
							next_st.count_down = 1'b1;
							next_st.count = `TMR8_MAX_LESS_ONE;
							next_st.compare_act = st.compare_buf;
						end else begin
							next_st.count = st.count + `TMR8_ONE;
						end
					end else if (st.count == `TMR8_ONE || at_bot) begin
						next_st.count_down = 1'b0;
						next_st.count = `TMR8_BOTTOM;
						next_st.overflow_flag = 1'b1;
					end else begin
						next_st.count = st.count - `TMR8_ONE;
					end
					if (top_special) begin
						if (at_max && !st.count_down) begin
							next_st.compare_output = !st.action[0];
						end
					end else if (hit && st.action[1]) begin
						// Bottom counts as up-slope, so compare at bottom stays low
						if (st.count_down && !at_bot) begin
							next_st.compare_output = !st.action[0];
						end else begin
							next_st.compare_output = st.action[0];
						end
					end
				end
				default: begin
					next_st.count = st.count + `TMR8_ONE;
					if (hit) begin
						next_st.compare_output = match_action(st.action, st.compare_output);
					end
					if (at_max) begin
						next_st.overflow_flag = 1'b1;
					end
				end
			endcase
		end

		// Register writes win over the tick for the count
		if (wr_done) begin
			if (addr_is(paddr, `TMR8_OFS_CTRL)) begin
				next_st.mode = tmr8_mode_t'(pwdata[`TMR8_CTRL_MODE_MSB:`TMR8_CTRL_MODE_LSB]);
				next_st.action = pwdata[`TMR8_CTRL_ACTION_MSB:`TMR8_CTRL_ACTION_LSB];
				next_st.clock_select = pwdata[`TMR8_CTRL_CS_MSB:`TMR8_CTRL_CS_LSB];
				// Force acts only outside PWM and never touches flags or count
				if (pwdata[`TMR8_CTRL_FORCE_BIT] && !is_pwm(st.mode)) begin
					next_st.compare_output = match_action(
						pwdata[`TMR8_CTRL_ACTION_MSB:`TMR8_CTRL_ACTION_LSB],
						next_st.compare_output);
				end
			end
			if (addr_is(paddr, `TMR8_OFS_COUNT)) begin
				next_st.count = pwdata[7:0];
				next_st.block = 1'b1;
			end
			if (addr_is(paddr, `TMR8_OFS_COMPARE)) begin
				next_st.compare_buf = pwdata[7:0];
				if (!is_pwm(st.mode)) begin
					next_st.compare_act = pwdata[7:0];
				end
			end
			if (addr_is(paddr, `TMR8_OFS_DIR)) begin
				next_st.direction = pwdata[`TMR8_DIR_BIT];
			end
		end

		// Leaving PWM must not strand a stale buffered compare
		if (!is_pwm(next_st.mode)) begin
			next_st.compare_act = next_st.compare_buf;
		end
		if (next_st.mode != tmr8_phase_pwm) begin
			next_st.count_down = 1'b0;
		end

		// Internal state kept even while the pin is not driven
		next_st.pin_out = next_st.compare_output;
		next_st.pin_oe_n = !(next_st.direction && next_st.action != `TMR8_ACT_OFF);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.pin_oe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign tick_bus.clock_select = st.clock_select;
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign compare_pin_out = st.pin_out;
	assign compare_pin_oe_n = st.pin_oe_n;

endmodule
`default_nettype wire

// ===== inc/tmr8_params.svh
// Register offsets, field positions, reset values and prescale counts of the timer
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH

`define TMR8_OFS_CTRL 8'h00
`define TMR8_OFS_COUNT 8'h04
`define TMR8_OFS_COMPARE 8'h08
`define TMR8_OFS_STATUS 8'h0c
`define TMR8_OFS_DIR 8'h10

`define TMR8_CTRL_MODE_LSB 0
`define TMR8_CTRL_MODE_MSB 1
`define TMR8_CTRL_ACTION_LSB 2
`define TMR8_CTRL_ACTION_MSB 3
`define TMR8_CTRL_CS_LSB 4
`define TMR8_CTRL_CS_MSB 6
`define TMR8_CTRL_FORCE_BIT 7
`define TMR8_STATUS_OVF_BIT 0
`define TMR8_STATUS_CMP_BIT 1
`define TMR8_DIR_BIT 0

`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_MAX_LESS_ONE 8'hfe
`define TMR8_ONE 8'h01

`define TMR8_RESET_BYTE 8'h00
`define TMR8_RESET_WORD 32'h0000_0000

`define TMR8_ACT_OFF 2'h0
`define TMR8_ACT_TOGGLE 2'h1
`define TMR8_ACT_CLEAR 2'h2
`define TMR8_ACT_SET 2'h3

`define TMR8_CS_STOP 3'h0
`define TMR8_CS_DIV1 3'h1
`define TMR8_CS_DIV8 3'h2
`define TMR8_CS_DIV64 3'h3
`define TMR8_CS_DIV256 3'h4
`define TMR8_CS_DIV1024 3'h5

`define TMR8_PRESCALE_WIDTH 10
`define TMR8_MASK_DIV8 10'h007
`define TMR8_MASK_DIV64 10'h03f
`define TMR8_MASK_DIV256 10'h0ff
`define TMR8_MASK_DIV1024 10'h3ff

`endif

// ===== inc/tmr8_pkg.sv
// Types shared by the timer modules
package tmr8_pkg;

	typedef enum logic [1:0] {
		tmr8_normal,
		tmr8_phase_pwm,
		tmr8_clear_on_match,
		tmr8_fast_pwm
	} tmr8_mode_t;

	typedef struct packed {
		logic [9:0] divider;
		logic tick;
	} tmr8_presc_state_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		tmr8_mode_t mode;
		logic [1:0] action;
		logic [2:0] clock_select;
		logic direction;
		logic [7:0] count;
		logic [7:0] compare_buf;
		logic [7:0] compare_act;
		logic count_down;
		logic match_pending;
		logic block;
		logic overflow_flag;
		logic compare_match_flag;
		logic compare_output;
		logic pin_out;
		logic pin_oe_n;
	} tmr8_state_t;

endpackage

// ===== inc/tmr8_tick_if.sv
// Clock select and timer tick between the timer and its prescaler
`timescale 1ns/100ps
`default_nettype none
interface tmr8_tick_if;
	logic [2:0] clock_select;
	logic tick;
	modport prescaler (input clock_select, output tick);
	modport timer (output clock_select, input tick);
endinterface
`default_nettype wire

// ===== hdl/tmr8_prescaler.sv
// Prescaler making the timer tick from the I/O clock
`timescale 1ns/100ps
`default_nettype none
`include "tmr8_params.svh"
module tmr8_prescaler
	import tmr8_pkg::*;
#(
	parameter int DIV_WIDTH = `TMR8_PRESCALE_WIDTH
) (
	input wire logic pclk,
	input wire logic presetn,
	tmr8_tick_if.prescaler tick_bus
);

	initial begin
		if (DIV_WIDTH != `TMR8_PRESCALE_WIDTH) begin
			$error("Prescaler width must be ten bits");
		end
	end

	tmr8_presc_state_t st;
	tmr8_presc_state_t next_st;

	// Divider runs free, so a select change takes effect within one period
	always_comb begin
		next_st = st;
		next_st.divider = st.divider + 10'h001;
		case (tick_bus.clock_select)
			`TMR8_CS_DIV1: next_st.tick = 1'b1;
			`TMR8_CS_DIV8: next_st.tick = (st.divider & `TMR8_MASK_DIV8) == `TMR8_MASK_DIV8;
			`TMR8_CS_DIV64: next_st.tick = (st.divider & `TMR8_MASK_DIV64) == `TMR8_MASK_DIV64;
			`TMR8_CS_DIV256: next_st.tick = (st.divider & `TMR8_MASK_DIV256) == `TMR8_MASK_DIV256;
			`TMR8_CS_DIV1024: next_st.tick = st.divider == `TMR8_MASK_DIV1024;
			default: next_st.tick = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_bus.tick = st.tick;

endmodule
`default_nettype wire

// ===== verification/tmr8_pin_model.sv
// Compare pin as seen on the board, with a pull-up
`timescale 1ns/100ps
`default_nettype none
module tmr8_pin_model (
	input wire logic compare_pin_out,
	input wire logic compare_pin_oe_n,
	output logic pin_level
);
	// Released pin floats up, so a stale drive value never shows
	assign pin_level = compare_pin_oe_n ? 1'b1 : compare_pin_out;
endmodule
`default_nettype wire

// ===== verification/tmr8_asserts.sv
// Port checker for the timer, bound into its top module
`timescale 1ns/100ps
`default_nettype none
module tmr8_asserts #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic compare_pin_out,
	input wire logic compare_pin_oe_n
);
	logic [6:0] ctl;
	logic [7:0] cmp;
	logic dir;
	logic pp;
	logic [9:0] st;
	logic [9:0] gap;
	logic wr;
	logic map;
	logic rise;
	logic run;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign map = paddr[1:0] == 2'h0 && paddr <= ADDR_WIDTH'(16);
	assign rise = compare_pin_out && !pp;
	// Periods only judged long after the last write, once buffers settled
	assign run = st == 10'h3ff && ctl[6:4] == 3'h1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= '0;
			cmp <= '0;
			dir <= 1'b0;
			pp <= 1'b0;
			st <= '0;
			gap <= '0;
		end else begin
			pp <= compare_pin_out;
			gap <= rise ? 10'h1 : gap + {9'h0, gap != 10'h3ff};
			st <= wr ? 10'h0 : st + {9'h0, st != 10'h3ff};
			if (wr && paddr == 'h0) ctl <= pwdata[6:0];
			if (wr && paddr == 'h8) cmp <= pwdata[7:0];
			if (wr && paddr == 'h10) dir <= pwdata[0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY_AFTER_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
		else $error("pready too long");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_UNMAPPED_ERR: assert property (psel && penable && !pready |=> pslverr == !map)
		else $error("pslverr wrong for address");
	AST_RDATA_HELD: assert property (!pready |-> $stable(prdata))
		else $error("prdata moved");
	AST_PIN_ENABLE: assert property (st == 10'h3ff |-> compare_pin_oe_n == !(dir && ctl[3:2] != 2'h0))
		else $error("pin enable wrong");
	AST_FAST_PERIOD: assert property (rise && run && ctl[1:0] == 2'h3 |-> gap == 10'd256)
		else $error("fast period wrong");
	AST_PHASE_PERIOD: assert property (rise && run && ctl[1:0] == 2'h1 |-> gap == 10'd510)
		else $error("phase period wrong");
	AST_TOGGLE_PERIOD: assert property (rise && run && ctl[3:0] == 4'h6 && cmp != 8'hff
		|-> gap == (10'(cmp) + 10'h1) << 1)
		else $error("toggle period wrong");
	AST_EXTREME_LEVEL: assert property (run && ctl[3:2] == 2'h2 && ((ctl[1:0] == 2'h3 && cmp == 8'hff)
		|| (ctl[1:0] == 2'h1 && cmp == 8'h00)) |-> compare_pin_out == ctl[1])
		else $error("extreme level wrong");
	CV_FAST: cover property (rise && run && ctl[1:0] == 2'h3);
	CV_PHASE: cover property (rise && run && ctl[1:0] == 2'h1);
	CV_TOGGLE: cover property (rise && run && ctl[1:0] == 2'h2);
	CV_UNMAPPED: cover property (pslverr);
endmodule
bind tmr8_top tmr8_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_tmr8_asserts (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .compare_pin_out(compare_pin_out),
	.compare_pin_oe_n(compare_pin_oe_n));
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the timer over APB
`timescale 1ns/100ps
`default_nettype none
module tb;
	import tmr8_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, pin_out, pin_oe_n, pin_level;
	logic [33:0] exp_q[$];
	logic [33:0] ent;
	logic [7:0] r;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	integer seed = 32'heb7a;
	initial forever #25 pclk = ~pclk;
	tmr8_top #(.ADDR_WIDTH(8)) u_tmr8_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .compare_pin_out(pin_out), .compare_pin_oe_n(pin_oe_n));
	tmr8_pin_model u_tmr8_pin_model (.compare_pin_out(pin_out), .compare_pin_oe_n(pin_oe_n),
		.pin_level(pin_level));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task print_verdict;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Queue holds {is_read, expected error, expected data}
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		int t;
		t = 0;
		exp_q.push_back({!w, a[1:0] != 2'h0 || a > 8'h10, e});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Stop, load count, clear flags, set compare, then start
	task automatic cfg(input logic [7:0] c, input logic [7:0] n, input logic [7:0] v);
		xfer(1'b1, 8'h00, 32'h0, 32'h0);
		xfer(1'b1, 8'h04, {24'h0, n}, 32'h0);
		xfer(1'b1, 8'h0c, 32'h3, 32'h0);
		xfer(1'b1, 8'h08, {24'h0, v}, 32'h0);
		xfer(1'b1, 8'h00, {24'h0, c}, 32'h0);
	endtask
	always @(posedge pclk) begin
		if (pready === 1'b1 && psel && penable && exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			chk({31'h0, pslverr}, {31'h0, ent[32]});
			if (ent[33]) chk(prdata, ent[31:0]);
		end
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) xfer(1'b0, 8'(i * 4), 32'h0, 32'h0);
		r = 8'($random(seed));
		xfer(1'b1, 8'h08, {24'h0, r}, 32'h0);
		xfer(1'b0, 8'h08, 32'h0, {24'h0, r});
		xfer(1'b1, 8'h00, 32'hff, 32'h0);
		xfer(1'b0, 8'h00, 32'h0, 32'h7f);
		xfer(1'b1, 8'h10, 32'h1, 32'h0);
		cfg(8'h16, 8'h00, 8'($random(seed)) & 8'h1f);
		repeat (1200) @(posedge pclk);
		xfer(1'b0, 8'h0c, 32'h0, 32'h2);
		// Compare below count must wait for the wrap, which sets overflow
		cfg(8'h16, 8'h50, 8'h10);
		repeat (250) @(posedge pclk);
		xfer(1'b0, 8'h0c, 32'h0, 32'h3);
		repeat (1100) @(posedge pclk);
		for (int m = 0; m < 4; m++) begin
			r = 8'h10 + (8'($random(seed)) & 8'h7f);
			cfg({4'h1, m[0] ? 2'h3 : 2'h2, m[1] ? 2'h1 : 2'h3}, 8'h00, r);
			repeat (1200) @(posedge pclk);
			xfer(1'b0, 8'h0c, 32'h0, 32'h3);
		end
		cfg(8'h1b, 8'h00, 8'hff);
		repeat (1200) @(posedge pclk);
		cfg(8'h19, 8'h00, 8'h00);
		repeat (1200) @(posedge pclk);
		xfer(1'b1, 8'h10, 32'h0, 32'h0);
		repeat (4) @(posedge pclk);
		chk({31'h0, pin_level}, 32'h1);
		print_verdict;
	end
endmodule
`default_nettype wire
